// ===== hw/qbx_pkg.sv
// Purpose: constants shared by the quasi-bidirectional port expander
// Assumes: bus clock and data are sampled by mclk at 125 MHz
// Notes:   7-bit address is a fixed upper nibble plus three select pins
package qbx_pkg;
  localparam logic [3:0] ADDR_FIXED_BITS = 4'h7;
  localparam logic [7:0] PORT_RESET_VAL  = 8'hff;
  localparam logic [6:0] GENERAL_CALL    = 7'h00;
  localparam int         SYNC_STAGES     = 2;
  localparam int         CLK_PERIOD_NS   = 8;
  // strong pull-up pulse lasts at most until the next bus clock fall
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_AACK   = 3'b011,
    ST_DATA   = 3'b010,
    ST_DACK   = 3'b110,
    ST_IGNORE = 3'b111
  } qbx_state_type;
endpackage : qbx_pkg

// ===== hw/qbx_sync.sv
// Purpose: two-flop synchroniser, one per bit
// Assumes: inputs come from outside the mclk domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module qbx_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : qbx_sync

// ===== hw/qbx_expander.sv
// Purpose: I2C responder driving an 8-bit quasi-bidirectional port
// Assumes: scl and sda sampled by mclk; rst stands for the power-on reset
// Notes:   open-drain lines are given as input, output and enable
// What this block does
// - detect start condition, sda falling while scl high, then receive address
// - address byte arrives msb first, lsb is direction, high means read
// - general call address is never acknowledged, sda stays released
// - own address acknowledged by holding sda low through ninth clock high
// - address is 0111 followed by the three address select pins
// - read sends port pin levels, pin 7 first and pin 0 last
// - write takes data byte as port outputs, bit n on pin n, then acks
// - written data bytes after the first acknowledged one are ignored
// - port outputs change only at rising clock edge of acknowledge
// - stop condition, sda rising while scl high, returns to idle
// - stop anywhere keeps latched outputs, drops partial byte and read
// - no reset pin; only power-on reset restores defaults
// - power-on reset clears bus state and sets all port pins high
// - alert asserts on any input change, cleared by access or revert
// - alert clears at ack: read after scl rise, write after scl fall
// - writing a bit high that was low enables strong pull-up until next scl fall
`timescale 1ns/1ps
module qbx_expander (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic [2:0] address_select_pins,
  input  wire logic [7:0] quasi_bidir_port_pins_in,
  output logic      [7:0] quasi_bidir_port_pins_out,
  output logic      [7:0] quasi_bidir_port_pins_oe,
  output logic      [7:0] strong_pullup_en,
  output logic      change_alert_n
);
  import qbx_pkg::*;

  logic [1:0]    bus_sync;
  logic [2:0]    asel_sync;
  logic [7:0]    pin_sync;
  qbx_state_type state_reg, state_next;
  logic [7:0]    shift_reg, shift_next;
  logic [3:0]    bit_reg, bit_next;
  logic          rd_reg, rd_next;
  logic          done_reg, done_next;
  logic          ack_drv_reg, ack_drv_next;
  logic          tx_bit_reg, tx_bit_next;
  logic [7:0]    port_reg, port_next;
  logic [7:0]    pull_reg, pull_next;
  logic [7:0]    snap_reg, snap_next;
  logic          alert_reg, alert_next;
  logic          scl_d_reg, sda_d_reg;
  logic          scl_s, sda_s;
  logic          scl_rise, scl_fall, start_det, stop_det;
  logic          addr_hit;

  // scl, sda, the select pins and the port pins pass through one synchroniser bank
  qbx_sync #(.WIDTH(13)) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({scl_in, sda_in, address_select_pins, quasi_bidir_port_pins_in}),
    .sync_out ({bus_sync, asel_sync, pin_sync})
  );

  assign scl_s     = bus_sync[1];
  assign sda_s     = bus_sync[0];
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // shift_reg holds the whole address byte once bit 0 is sampled; bits 7..1 are the address
  assign addr_hit  = ({shift_reg[7:1]} == {ADDR_FIXED_BITS, asel_sync}) &&
                     ({shift_reg[7:1]} != GENERAL_CALL);

  always_comb begin
    state_next   = state_reg;
    shift_next   = shift_reg;
    bit_next     = bit_reg;
    rd_next      = rd_reg;
    done_next    = done_reg;
    ack_drv_next = ack_drv_reg;
    tx_bit_next  = tx_bit_reg;
    port_next    = port_reg;
    pull_next    = pull_reg;
    snap_next    = snap_reg;
    alert_next   = alert_reg;
    if (scl_fall) begin
      pull_next = 8'h00;
    end
    // alert follows any difference from the last snapshot; reverting clears it
    alert_next = (pin_sync != snap_reg);
    if (start_det) begin
      state_next   = ST_ADDR;
      bit_next     = 4'h0;
      shift_next   = 8'h00;
      ack_drv_next = 1'b0;
      tx_bit_next  = 1'b0;
      done_next    = 1'b0;
    end else if (stop_det) begin
      state_next   = ST_IDLE;
      ack_drv_next = 1'b0;
      tx_bit_next  = 1'b0;
      bit_next     = 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_next   = bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == 4'h8) begin
            if (addr_hit) begin
              rd_next      = shift_reg[0];
              ack_drv_next = 1'b1;
              state_next   = ST_AACK;
            end else begin
              state_next = ST_IGNORE;
            end
          end
        end
        ST_AACK: begin
          if (scl_rise && rd_reg) begin
            // read: alert clears after the acknowledge clock rises
            snap_next  = pin_sync;
            alert_next = 1'b0;
            shift_next = pin_sync;
          end
          if (scl_fall) begin
            ack_drv_next = 1'b0;
            bit_next     = 4'h0;
            state_next   = ST_DATA;
            if (rd_reg) begin
              tx_bit_next = ~shift_reg[7];
              shift_next  = {shift_reg[6:0], 1'b0};
            end
          end
        end
        ST_DATA: begin
          if (scl_rise) begin
            bit_next = bit_reg + 4'h1;
            if (!rd_reg) begin
              shift_next = {shift_reg[6:0], sda_s};
            end
          end
          if (scl_fall) begin
            if (rd_reg) begin
              if (bit_reg == 4'h8) begin
                tx_bit_next = 1'b0;
                state_next  = ST_DACK;
              end else begin
                tx_bit_next = ~shift_reg[7];
                shift_next  = {shift_reg[6:0], 1'b0};
              end
            end else if (bit_reg == 4'h8) begin
              ack_drv_next = ~done_reg;
              state_next   = ST_DACK;
            end
          end
        end
        ST_DACK: begin
          if (scl_rise && !rd_reg && !done_reg) begin
            port_next = shift_reg;
            pull_next = shift_reg & ~port_reg;
            done_next = 1'b1;
          end
          if (scl_rise && rd_reg) begin
            if (sda_s) begin
              // not-acknowledge ends the read; stay off the line until stop or start
              state_next = ST_IGNORE;
            end else begin
              // commander acknowledge; a new sample is taken for the next byte
              shift_next = pin_sync;
            end
          end
          if (scl_fall) begin
            if (!rd_reg && ack_drv_reg) begin
              snap_next  = pin_sync;
              alert_next = 1'b0;
            end
            ack_drv_next = 1'b0;
            bit_next     = 4'h0;
            state_next   = ST_DATA;
            if (rd_reg) begin
              tx_bit_next = ~shift_reg[7];
              shift_next  = {shift_reg[6:0], 1'b0};
            end
          end
        end
        ST_IGNORE: begin
          ack_drv_next = 1'b0;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      shift_reg   <= 8'h00;
      bit_reg     <= 4'h0;
      rd_reg      <= 1'b0;
      done_reg    <= 1'b0;
      ack_drv_reg <= 1'b0;
      tx_bit_reg  <= 1'b0;
      port_reg    <= PORT_RESET_VAL;
      pull_reg    <= 8'h00;
      snap_reg    <= PORT_RESET_VAL;
      alert_reg   <= 1'b0;
      scl_d_reg   <= 1'b1;
      sda_d_reg   <= 1'b1;
    end else begin
      state_reg   <= state_next;
      shift_reg   <= shift_next;
      bit_reg     <= bit_next;
      rd_reg      <= rd_next;
      done_reg    <= done_next;
      ack_drv_reg <= ack_drv_next;
      tx_bit_reg  <= tx_bit_next;
      port_reg    <= port_next;
      pull_reg    <= pull_next;
      snap_reg    <= snap_next;
      alert_reg   <= alert_next;
      scl_d_reg   <= scl_s;
      sda_d_reg   <= sda_s;
    end
  end

  // open drain: output always low, enable pulls the line
  assign sda_out                   = 1'b0;
  assign sda_oe                    = ack_drv_reg | tx_bit_reg;
  assign quasi_bidir_port_pins_out = port_reg;
  assign quasi_bidir_port_pins_oe  = ~port_reg;
  assign strong_pullup_en          = pull_reg;
  assign change_alert_n            = ~alert_reg;

  property p_start_addr;
    @(posedge mclk) disable iff (rst) start_det |=> state_reg == ST_ADDR;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_stop_idle;
    @(posedge mclk) disable iff (rst) (stop_det && !start_det) |=> state_reg == ST_IDLE && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  property p_no_ack_mismatch;
    @(posedge mclk) disable iff (rst) state_reg == ST_IGNORE |-> !sda_oe;
  endproperty
  a_no_ack_mismatch: assert property (p_no_ack_mismatch) else $error("line driven after mismatch");

  property p_ack_hold;
    @(posedge mclk) disable iff (rst) (state_reg == ST_AACK && scl_s) |-> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("address ack not held");

  property p_port_stable;
    @(posedge mclk) disable iff (rst) !(state_reg == ST_DACK && scl_rise) |=> $stable(port_reg);
  endproperty
  a_port_stable: assert property (p_port_stable) else $error("port changed outside ack");

  property p_once;
    @(posedge mclk) disable iff (rst) (done_reg && !start_det) |=> $stable(port_reg);
  endproperty
  a_once: assert property (p_once) else $error("second byte changed port");

  property p_pull_off;
    @(posedge mclk) disable iff (rst) scl_fall |=> pull_reg == 8'h00;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull-up not released");

  property p_read_release;
    @(posedge mclk) disable iff (rst) (state_reg == ST_DACK && rd_reg) |-> !sda_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("line driven in read ack slot");

  property p_nack_release;
    @(posedge mclk) disable iff (rst) (state_reg == ST_DACK && rd_reg && scl_rise && sda_s) |=>
      state_reg == ST_IGNORE && !sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("read not ended by not-acknowledge");

  property p_read_clear;
    @(posedge mclk) disable iff (rst) (state_reg == ST_AACK && rd_reg && scl_rise) |=> change_alert_n;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("alert not cleared by read");

  property p_alert;
    @(posedge mclk) disable iff (rst) (pin_sync != snap_reg) ##1 (pin_sync == $past(pin_sync)) &&
      (snap_reg == $past(snap_reg)) |-> !change_alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missing on change");

  c_write: cover property (@(posedge mclk) state_reg == ST_DACK && !rd_reg && scl_rise);
  c_read:  cover property (@(posedge mclk) state_reg == ST_DACK && rd_reg);
  c_miss:  cover property (@(posedge mclk) state_reg == ST_IGNORE);
  c_alert: cover property (@(posedge mclk) !change_alert_n);
  c_nack:  cover property (@(posedge mclk) state_reg == ST_DACK && rd_reg && scl_rise && sda_s);
endmodule : qbx_expander

// ===== test/qbx_commander.sv
// Purpose: bus commander model driving scl and pulling sda low
// Assumes: every move is made at a falling mclk edge; scl half period 5 mclk
// Notes:   sda keeps each bit level until the next bit is set; released, the pull-up makes it high
`timescale 1ns/1ps
module qbx_commander (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge mclk);
  endtask : hc
  // sda falls while scl high; also serves as repeated start
  task automatic start_cond();
    hc(2);
    sda_low = 1'b0;
    hc(3);
    scl = 1'b1;
    hc(5);
    sda_low = 1'b1;
    hc(5);
    scl = 1'b0;
  endtask : start_cond
  // data changes 2 mclk after scl fall, sampled mid high phase
  task automatic bit_slot(input logic b, output logic rb);
    hc(2);
    sda_low = ~b;
    hc(3);
    scl = 1'b1;
    hc(2);
    rb = sda;
    hc(3);
    scl = 1'b0;
  endtask : bit_slot
  task automatic put_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(tx[i], rx[i]);
    end
  endtask : put_byte
  task automatic ack_slot(input logic b, output logic ack);
    logic r;
    bit_slot(b, r);
    ack = ~r;
  endtask : ack_slot
  task automatic stop_cond();
    hc(2);
    sda_low = 1'b1;
    hc(3);
    scl = 1'b1;
    hc(5);
    sda_low = 1'b0;
    hc(5);
  endtask : stop_cond
endmodule : qbx_commander

// ===== test/i2c_quasi_bidir_port_expander_bench.sv
// Purpose: self-checking bench for the port expander
// Assumes: port pins are wired as outside level and-ed with driven value
// Notes:   xorshift stimulus, fixed seed
`timescale 1ns/1ps
module i2c_quasi_bidir_port_expander_bench;
  import qbx_pkg::*;
  logic        mclk, rst, scl, cmd_low, sda_oe, sda_out, alert_n, ack;
  logic [2:0]  sel;
  logic [7:0]  ext, pin_out, pin_oe, spu, rx, last;
  logic [31:0] rng;
  int          err_total, check_count;
  wire         sda  = ~(cmd_low | sda_oe);
  wire [7:0]   pins = ext & pin_out;
  qbx_expander u_qbx_expander (.mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_select_pins(sel), .quasi_bidir_port_pins_in(pins),
    .quasi_bidir_port_pins_out(pin_out), .quasi_bidir_port_pins_oe(pin_oe), .strong_pullup_en(spu),
    .change_alert_n(alert_n));
  qbx_commander u_qbx_commander (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(cmd_low));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic logic [7:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : nxt
  function automatic logic [7:0] own(input logic rw);
    return {ADDR_FIXED_BITS, sel, rw};
  endfunction : own
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_alert(input logic exp);
    int i;
    for (i = 0; i < 20 && alert_n !== exp; i++) @(negedge mclk);
    if (i == 20) begin
      err_total++;
      conclude();
    end
  endtask : wait_alert
  task automatic write_xfer(input logic [7:0] ab, input logic [7:0] d, input logic hit);
    u_qbx_commander.start_cond();
    u_qbx_commander.put_byte(ab, rx);
    u_qbx_commander.ack_slot(1'b1, ack);
    check({7'h0, ack}, {7'h0, hit});
    u_qbx_commander.put_byte(d, rx);
    check(pin_out, last);
    fork
      u_qbx_commander.ack_slot(1'b1, ack);
      begin
        u_qbx_commander.hc(9);
        check(spu, hit ? (d & ~last) : 8'h00);
      end
    join
    check({7'h0, ack}, {7'h0, hit});
    if (hit) last = d;
    check(pin_out, last);
    check(pin_oe, ~last);
    u_qbx_commander.hc(6);
    check(spu, 8'h00);
    u_qbx_commander.put_byte(~d, rx);
    u_qbx_commander.ack_slot(1'b1, ack);
    check({7'h0, ack}, 8'h00);
    check(pin_out, last);
    u_qbx_commander.stop_cond();
  endtask : write_xfer
  task automatic read_xfer();
    u_qbx_commander.start_cond();
    u_qbx_commander.put_byte(own(1'b1), rx);
    u_qbx_commander.ack_slot(1'b1, ack);
    check({7'h0, ack}, 8'h01);
    u_qbx_commander.put_byte(8'hff, rx);
    check(rx, ext & last);
    u_qbx_commander.ack_slot(1'b1, ack);
    check({7'h0, ack}, 8'h00);
    u_qbx_commander.stop_cond();
  endtask : read_xfer
  initial begin
    rng = 32'h89e0;
    rst = 1'b1;
    sel = 3'h0;
    ext = 8'hff;
    last = PORT_RESET_VAL;
    err_total = 0;
    check_count = 0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    u_qbx_commander.hc(4);
    check(pin_out, PORT_RESET_VAL);
    check({spu[0], sda_oe, 5'h0, alert_n}, 8'h01);
    for (int s = 0; s < 8; s++) begin
      sel = s[2:0];
      write_xfer(own(1'b0), nxt(), 1'b1);
      ext = nxt();
      read_xfer();
    end
    ext = 8'hff;
    write_xfer({GENERAL_CALL, 1'b0}, 8'h00, 1'b0);
    write_xfer({4'h6, sel, 1'b0}, 8'h00, 1'b0);
    write_xfer({ADDR_FIXED_BITS, ~sel, 1'b0}, 8'h00, 1'b0);
    // stop inside a data byte leaves the latch alone
    u_qbx_commander.start_cond();
    u_qbx_commander.put_byte(own(1'b0), rx);
    u_qbx_commander.ack_slot(1'b1, ack);
    for (int i = 0; i < 4; i++) u_qbx_commander.bit_slot(1'b0, ack);
    u_qbx_commander.stop_cond();
    check(pin_out, last);
    write_xfer(own(1'b0), 8'hff, 1'b1);
    read_xfer();
    ext = nxt() & 8'hfe;
    wait_alert(1'b0);
    write_xfer({4'h6, sel, 1'b0}, 8'h00, 1'b0);
    check({7'h0, alert_n}, 8'h00);
    read_xfer();
    check({7'h0, alert_n}, 8'h01);
    ext = 8'hff;
    wait_alert(1'b0);
    ext = rx;
    wait_alert(1'b1);
    conclude();
  end
endmodule : i2c_quasi_bidir_port_expander_bench
